/* File: core/pac_map.vh */
// register map and field constants for the port a pad control block
`ifndef PAC_MAP_VH
`define PAC_MAP_VH
// register byte offsets
`define PAC_PULLUP_OFS    4'h0
`define PAC_SLEW_OFS      4'h4
`define PAC_DRIVE_OFS     4'h8
`define PAC_DIR_OFS       4'hc
// field layout
`define PAC_PIN_W         6
`define PAC_OUT_ONLY_PIN  3'h4
`define PAC_IN_ONLY_PIN   3'h5
// reset values
`define PAC_CTRL_RST      6'h00
`define PAC_DIR_RST       6'h00
`define PAC_DEBUG_RST     1'h1
`define PAC_ADDR_RST      4'h0
`define PAC_IDX_RST       2'h0
`define PAC_WORD_RST      32'h00000000
// bus answers
`define PAC_RESP_OKAY     2'h0
`define PAC_RESP_SLVERR   2'h2
// register slots
`define PAC_NREG          4
`define PAC_IDX_PULLUP    2'h0
`define PAC_IDX_SLEW      2'h1
`define PAC_IDX_DRIVE     2'h2
`define PAC_IDX_DIR       2'h3
`endif

/* File: core/pac_regfile.v */
// small register store with registered read data for the pad control block
`timescale 1ns/1ns
`include "pac_map.vh"
module pac_regfile #(
    parameter WIDTH = 6,
    parameter DEPTH = 4
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             rst_i,
    // write port
    input  wire             we_i,
    input  wire [1:0]       waddr_i,
    input  wire [WIDTH-1:0] wdata_i,
    // read port
    input  wire [1:0]       raddr_i,
    output reg  [WIDTH-1:0] rdata_o,
    // all words at once for the pad logic
    output wire [WIDTH*DEPTH-1:0] all_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    genvar g;
    // ==========================================
    // storage words, cleared by reset
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_word
            always @(posedge clk_i) begin
                if (rst_i) begin
                    mem_q[g] <= `PAC_CTRL_RST;
                end else if (we_i && (waddr_i == g)) begin
                    mem_q[g] <= wdata_i;
                end
            end
            assign all_o[g*WIDTH +: WIDTH] = mem_q[g];
        end
    endgenerate
    // ==========================================
    // registered read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= {WIDTH{1'b0}};
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule

/* File: core/pac_top.v */
// port a pad control: pullup, slew and drive registers with pin gating
// bus and pad timing
// write address and write data are taken in either order, each at its own ready.
// the store is written and the response raised on the edge after both are held.
// read data stand one edge after the read address is taken.
// the store's read register loads on the take edge, so the index is steered there.
// unmapped addresses answer with an error and change nothing.
// only write strobe lane zero gates a write; a clear lane is still answered okay.
// every pad output follows its registers and ownership inputs one edge later.
// pin four drives whenever analog does not own it; pin five never drives.
// register bits of the fixed pins still store and read back what was written.
`timescale 1ns/1ns
`include "pac_map.vh"
module pac_top #(
    parameter PINS = 6
) (
    // clock and reset
    input  wire            REF_CLK_I,
    input  wire            SYS_RST_I,
    // axi4-lite write address
    input  wire [3:0]      AWADDR_I,
    input  wire            AWVALID_I,
    output reg             AWREADY_O,
    // axi4-lite write data
    input  wire [31:0]     WDATA_I,
    input  wire [3:0]      WSTRB_I,
    input  wire            WVALID_I,
    output reg             WREADY_O,
    // axi4-lite write response
    output reg  [1:0]      BRESP_O,
    output reg             BVALID_O,
    input  wire            BREADY_I,
    // axi4-lite read address
    input  wire [3:0]      ARADDR_I,
    input  wire            ARVALID_I,
    output reg             ARREADY_O,
    // axi4-lite read data
    output reg  [31:0]     RDATA_O,
    output reg  [1:0]      RRESP_O,
    output reg             RVALID_O,
    input  wire            RREADY_I,
    // peripheral and analog ownership (same clock)
    input  wire [PINS-1:0] PERIPH_EN_I,
    input  wire [PINS-1:0] PERIPH_OE_I,
    input  wire [PINS-1:0] ANALOG_EN_I,
    input  wire            DEBUG_EN_I,
    // pad controls
    output reg  [PINS-1:0] PAD_OE_O,
    output reg  [PINS-1:0] PAD_PULLUP_O,
    output reg  [PINS-1:0] PAD_SLEW_O,
    output reg  [PINS-1:0] PAD_HIDRIVE_O,
    output reg             PAD_DEBUG_O
);
    // ==========================================
    // address decode helper
    function [2:0] dec;
        input [3:0] a;
        begin
            case (a)
                `PAC_PULLUP_OFS: dec = {1'b1, `PAC_IDX_PULLUP};
                `PAC_SLEW_OFS:   dec = {1'b1, `PAC_IDX_SLEW};
                `PAC_DRIVE_OFS:  dec = {1'b1, `PAC_IDX_DRIVE};
                `PAC_DIR_OFS:    dec = {1'b1, `PAC_IDX_DIR};
                default:         dec = 3'h0;
            endcase
        end
    endfunction

    // ==========================================
    // write channel: latch address and data in either order
    reg        aw_have_q;
    reg [3:0]  aw_addr_q;
    reg        w_have_q;
    reg [31:0] w_data_q;
    reg        w_lane0_q;
    wire       aw_take = AWVALID_I && AWREADY_O;
    wire       w_take  = WVALID_I && WREADY_O;
    wire       do_write = aw_have_q && w_have_q && !BVALID_O;
    wire [2:0] wdec     = dec(aw_addr_q);
    wire       reg_we   = do_write && wdec[2] && w_lane0_q;

    // readies open only while idle, and shut on the edge of their own take
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            AWREADY_O <= 1'b0;
            WREADY_O  <= 1'b0;
        end else begin
            AWREADY_O <= !aw_have_q && !aw_take && !BVALID_O;
            WREADY_O  <= !w_have_q && !w_take && !BVALID_O;
        end
    end

    // address and data capture in either order, both freed by the write
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= `PAC_ADDR_RST;
            w_have_q  <= 1'b0;
            w_data_q  <= `PAC_WORD_RST;
            w_lane0_q <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= AWADDR_I;
            end
            if (w_take) begin
                w_have_q  <= 1'b1;
                w_data_q  <= WDATA_I;
                w_lane0_q <= WSTRB_I[0];
            end
            // the store is written on this same edge
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
        end
    end

    // response raised once both halves are held, dropped at its handshake
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            BVALID_O <= 1'b0;
            BRESP_O  <= `PAC_RESP_OKAY;
        end else if (do_write) begin
            BVALID_O <= 1'b1;
            BRESP_O  <= wdec[2] ? `PAC_RESP_OKAY : `PAC_RESP_SLVERR;
        end else if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
        end
    end

    // ==========================================
    // read channel: one read at a time, data two cycles after address
    reg        rd_pend_q;
    reg        rd_ok_q;
    reg [1:0]  rd_idx_q;
    wire       ar_take = ARVALID_I && ARREADY_O;
    wire [2:0] rdec    = dec(ARADDR_I);
    // the store's read register loads on the take edge itself, so steer it there
    wire [1:0] rd_addr = ar_take ? rdec[1:0] : rd_idx_q;
    wire [PINS-1:0] rf_rdata;

    // address ready opens only with no read under way
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            ARREADY_O <= 1'b0;
        end else begin
            ARREADY_O <= !ar_take && !rd_pend_q && !RVALID_O;
        end
    end

    // read sequencing: capture the index, then present the stored word
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            rd_pend_q <= 1'b0;
            rd_ok_q   <= 1'b0;
            rd_idx_q  <= `PAC_IDX_RST;
            RVALID_O  <= 1'b0;
            RDATA_O   <= `PAC_WORD_RST;
            RRESP_O   <= `PAC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                rd_pend_q <= 1'b1;
                rd_ok_q   <= rdec[2];
                rd_idx_q  <= rdec[1:0];
            end else if (rd_pend_q) begin
                rd_pend_q <= 1'b0;
                RVALID_O  <= 1'b1;
                // upper bits read as zero
                RDATA_O   <= rd_ok_q ? {{(32-PINS){1'b0}}, rf_rdata} : `PAC_WORD_RST;
                RRESP_O   <= rd_ok_q ? `PAC_RESP_OKAY : `PAC_RESP_SLVERR;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O  <= 1'b0;
            end
        end
    end

    // ==========================================
    // register store, each word written only at its own address
    wire [PINS*`PAC_NREG-1:0] rf_all;
    pac_regfile #(
        .WIDTH (PINS),
        .DEPTH (`PAC_NREG)
    ) u_regs (
        .clk_i   (REF_CLK_I),
        .rst_i   (SYS_RST_I),
        .we_i    (reg_we),
        .waddr_i (wdec[1:0]),
        .wdata_i (w_data_q[PINS-1:0]),
        .raddr_i (rd_addr),
        .rdata_o (rf_rdata),
        .all_o   (rf_all)
    );
    wire [PINS-1:0] pullup_enable_bits = rf_all[0*PINS +: PINS];
    wire [PINS-1:0] slew_enable_bits   = rf_all[1*PINS +: PINS];
    wire [PINS-1:0] drive_select_bits  = rf_all[2*PINS +: PINS];
    wire [PINS-1:0] direction_bits     = rf_all[3*PINS +: PINS];

    // ==========================================
    // per-pin pad gating
    reg [PINS-1:0] oe_d;
    reg [PINS-1:0] pu_d;
    reg [PINS-1:0] sl_d;
    reg [PINS-1:0] hd_d;
    integer n;
    always @* begin
        oe_d = {PINS{1'b0}};
        pu_d = {PINS{1'b0}};
        sl_d = {PINS{1'b0}};
        hd_d = {PINS{1'b0}};
        for (n = 0; n < PINS; n = n + 1) begin
            // peripheral steers the buffer when enabled, else direction bit
            oe_d[n] = PERIPH_EN_I[n] ? PERIPH_OE_I[n] : direction_bits[n];
            if (n == `PAC_OUT_ONLY_PIN) begin
                oe_d[n] = 1'b1;
            end
            if (n == `PAC_IN_ONLY_PIN) begin
                oe_d[n] = 1'b0;
            end
            // analog ownership disables the output buffer
            if (ANALOG_EN_I[n]) begin
                oe_d[n] = 1'b0;
            end
            pu_d[n] = pullup_enable_bits[n] && !oe_d[n] && !ANALOG_EN_I[n];
            if (n == `PAC_OUT_ONLY_PIN) begin
                pu_d[n] = 1'b0;
            end
            sl_d[n] = slew_enable_bits[n] && oe_d[n];
            hd_d[n] = drive_select_bits[n] && oe_d[n];
            if (n == `PAC_IN_ONLY_PIN) begin
                sl_d[n] = 1'b0;
                hd_d[n] = 1'b0;
            end
        end
    end

    // ==========================================
    // registered pad outputs; reset leaves inputs without pullup
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            PAD_OE_O      <= {PINS{1'b0}};
            PAD_PULLUP_O  <= {PINS{1'b0}};
            PAD_SLEW_O    <= {PINS{1'b0}};
            PAD_HIDRIVE_O <= {PINS{1'b0}};
        end else begin
            PAD_OE_O      <= oe_d;
            PAD_PULLUP_O  <= pu_d;
            PAD_SLEW_O    <= sl_d;
            PAD_HIDRIVE_O <= hd_d;
        end
    end

    // debug ownership of the output-only pin passes through; reset hands it to debug
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            PAD_DEBUG_O <= `PAC_DEBUG_RST;
        end else begin
            PAD_DEBUG_O <= DEBUG_EN_I;
        end
    end
endmodule

/* File: verif/pac_pads.sv */
// behavioural pad drivers and external pins of port a
`timescale 1ns/1ns
module pac_pads (
    // clock
    input  wire        clk_i,
    // pad controls and driven data
    input  wire [5:0]  oe_i,
    input  wire [5:0]  pullup_i,
    input  wire [5:0]  data_i,
    // pin levels
    output logic [5:0] pin_o
);
    logic [5:0] flt_q = 6'h15;
    // an undriven pin without pullup wanders every cycle
    always @(posedge clk_i) flt_q <= ~flt_q;
    // driver wins, then pullup, then floating level
    assign pin_o = (oe_i & data_i) | (~oe_i & (pullup_i | flt_q));
endmodule

/* File: verif/pac_top_chk.sv */
// concurrent checks on the pad control top ports
`timescale 1ns/1ns
module pac_top_chk #(
    parameter PINS = 6
) (
    // clock and reset
    input wire            REF_CLK_I,
    input wire            SYS_RST_I,
    // read handshake
    input wire            ARVALID_I,
    input wire            ARREADY_O,
    input wire            RVALID_O,
    // ownership inputs
    input wire [PINS-1:0] PERIPH_EN_I,
    input wire [PINS-1:0] PERIPH_OE_I,
    input wire [PINS-1:0] ANALOG_EN_I,
    // pad controls
    input wire [PINS-1:0] PAD_OE_O,
    input wire [PINS-1:0] PAD_PULLUP_O,
    input wire [PINS-1:0] PAD_SLEW_O,
    input wire [PINS-1:0] PAD_HIDRIVE_O
);
    // ==========================================
    // pad gating relations and read answer delay
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    a_pull_vs_out: assert property ((PAD_PULLUP_O & PAD_OE_O) == 6'h00)
        else $error("pullup on while pin drives");
    a_pull_analog: assert property (!$past(SYS_RST_I) |-> (PAD_PULLUP_O & $past(ANALOG_EN_I)) == 6'h00)
        else $error("pullup on while analog owns pin");
    a_pin4_nopull: assert property (PAD_PULLUP_O[4] == 1'b0)
        else $error("pullup on output-only pin");
    a_pin4_drives: assert property (!$past(SYS_RST_I) |-> PAD_OE_O[4] == !$past(ANALOG_EN_I[4]))
        else $error("output-only pin not driving");
    a_pin5_quiet: assert property ({PAD_OE_O[5], PAD_SLEW_O[5], PAD_HIDRIVE_O[5]} == 3'h0)
        else $error("input-only pin has output controls");
    a_slew_input: assert property ((PAD_SLEW_O & ~PAD_OE_O) == 6'h00)
        else $error("slew active on input pin");
    a_drive_input: assert property ((PAD_HIDRIVE_O & ~PAD_OE_O) == 6'h00)
        else $error("high drive active on input pin");
    a_periph_steers: assert property (!$past(SYS_RST_I) |-> (((PAD_OE_O ^ $past(PERIPH_OE_I))
        & $past(PERIPH_EN_I) & ~$past(ANALOG_EN_I)) & 6'h0f) == 6'h00)
        else $error("peripheral does not steer buffer");
    a_read_delay: assert property (ARVALID_I && ARREADY_O |-> ##2 RVALID_O)
        else $error("read answer late");
    // main scenarios reached
    c_pullup: cover property (|PAD_PULLUP_O);
    c_periph: cover property (|(PERIPH_EN_I & ~PERIPH_OE_I));
    c_analog: cover property (|(ANALOG_EN_I & 6'h0f));
endmodule

bind pac_top pac_top_chk #(.PINS(PINS)) CHK (.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I),
    .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
    .PERIPH_EN_I(PERIPH_EN_I), .PERIPH_OE_I(PERIPH_OE_I), .ANALOG_EN_I(ANALOG_EN_I),
    .PAD_OE_O(PAD_OE_O), .PAD_PULLUP_O(PAD_PULLUP_O), .PAD_SLEW_O(PAD_SLEW_O),
    .PAD_HIDRIVE_O(PAD_HIDRIVE_O));

/* File: verif/test_port_a_pad_control.sv */
// self-checking bench for the port a pad control block
`timescale 1ns/1ns
`include "pac_map.vh"
module test_port_a_pad_control;
    typedef struct packed {logic [5:0] dir, pu, sl, dr, pen, poe, aen, eoe, epu, esl, ehd;} pac_row_t;
    // stimulus rows 0 and 1 select high drive on every pin at once
    pac_row_t    rows [4] = '{'{6'h00, 6'h3f, 6'h3f, 6'h3f, 6'h00, 6'h00, 6'h00, 6'h10, 6'h2f, 6'h10, 6'h10},
                              '{6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h00, 6'h00, 6'h00, 6'h1f, 6'h20, 6'h1f, 6'h1f},
                              '{6'h0f, 6'h3f, 6'h15, 6'h2a, 6'h03, 6'h01, 6'h0c, 6'h11, 6'h22, 6'h11, 6'h00},
                              '{6'h2a, 6'h15, 6'h3f, 6'h2a, 6'h20, 6'h00, 6'h10, 6'h0a, 6'h05, 6'h0a, 6'h0a}};
    logic        clk = 1'b0, rst = 1'b1, dbg_en = 1'b1;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rdat;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0]  rresp, bresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, dbg, a, w, b;
    logic [5:0]  pen = 6'h00, poe = 6'h00, aen = 6'h00, oe, pu, sl, hd, pins;
    int          error_cnt = 0, check_count = 0, cyc = 0, i;
    // ==========================================
    // design, pads and clock
    pac_top #(.PINS(6)) DUT (.REF_CLK_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .PERIPH_EN_I(pen), .PERIPH_OE_I(poe), .ANALOG_EN_I(aen), .DEBUG_EN_I(dbg_en),
        .PAD_OE_O(oe), .PAD_PULLUP_O(pu), .PAD_SLEW_O(sl), .PAD_HIDRIVE_O(hd), .PAD_DEBUG_O(dbg));
    pac_pads PADS (.clk_i(clk), .oe_i(oe), .pullup_i(pu), .data_i(6'h2a), .pin_o(pins));
    always #5 clk = ~clk;
    // ==========================================
    // checking and closing
    task chk(input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test;
        end
    end
    // ==========================================
    // bus master tasks
    task axi_wr(input [3:0] ad, input [31:0] d, input [3:0] s, input [1:0] er);
        @(posedge clk);
        awaddr <= ad;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            a = awready;
            w = wready;
            b = bvalid;
            resp = bresp;
            @(posedge clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
        chk(resp, er);
    endtask
    task axi_rd(input [3:0] ad, input [31:0] ed, input [1:0] er);
        @(posedge clk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            a = arready;
            b = rvalid;
            rdat = rdata;
            resp = rresp;
            @(posedge clk);
            if (a) arvalid <= 1'b0;
        end while (!b);
        rready <= 1'b0;
        chk(rdat, ed);
        chk(resp, er);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk({oe, pu, 5'h00, dbg}, 32'h1);
        @(posedge clk);
        rst <= 1'b0;
        axi_rd(`PAC_PULLUP_OFS, 32'h0, `PAC_RESP_OKAY);
        axi_rd(`PAC_DRIVE_OFS, 32'h0, `PAC_RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            pen <= rows[i].pen;
            poe <= rows[i].poe;
            aen <= rows[i].aen;
            axi_wr(`PAC_PULLUP_OFS, {26'h0, rows[i].pu}, 4'hf, `PAC_RESP_OKAY);
            axi_wr(`PAC_SLEW_OFS, {26'h0, rows[i].sl}, 4'hf, `PAC_RESP_OKAY);
            axi_wr(`PAC_DRIVE_OFS, {26'h0, rows[i].dr}, 4'hf, `PAC_RESP_OKAY);
            axi_wr(`PAC_DIR_OFS, {26'h0, rows[i].dir}, 4'hf, `PAC_RESP_OKAY);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(oe, rows[i].eoe);
            chk(pu, rows[i].epu);
            chk(sl, rows[i].esl);
            chk(hd, rows[i].ehd);
            chk(pins & (oe | pu), (oe & 6'h2a) | (pu & ~oe));
        end
        // awkward cases after the table
        axi_rd(`PAC_PULLUP_OFS, 32'h15, `PAC_RESP_OKAY);
        axi_wr(`PAC_SLEW_OFS, 32'hffffffff, 4'hf, `PAC_RESP_OKAY);
        axi_rd(`PAC_SLEW_OFS, 32'h3f, `PAC_RESP_OKAY);
        axi_wr(`PAC_SLEW_OFS, 32'h0, 4'h0, `PAC_RESP_OKAY);
        axi_rd(`PAC_SLEW_OFS, 32'h3f, `PAC_RESP_OKAY);
        axi_wr(4'h2, 32'h1, 4'hf, `PAC_RESP_SLVERR);
        axi_rd(4'h2, 32'h0, `PAC_RESP_SLVERR);
        @(posedge clk);
        rst <= 1'b1;
        dbg_en <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({oe, pu, 5'h00, dbg}, 32'h1);
        @(posedge clk);
        rst <= 1'b0;
        axi_rd(`PAC_SLEW_OFS, 32'h0, `PAC_RESP_OKAY);
        chk(dbg, 32'h0);
        end_of_test;
    end
endmodule
